// ==== core/floppy_ctrl_pkg.sv ====
// constants for the floppy controller host phase sequencer
package floppy_ctrl_pkg;
  // register indices; the byte address is four times the index
  localparam logic [3:0] IX_MSR = 4'h4;
  localparam logic [3:0] IX_DATA = 4'h5;
  localparam logic [3:0] IX_DIRDCR = 4'h7;
  localparam logic [3:0] IX_ISTS = 4'h8;
  localparam logic [3:0] IX_IEN = 4'h9;
  localparam logic [3:0] IX_ICLR = 4'hA;
  localparam logic [3:0] IX_XLEN = 4'hB;
  localparam int ADR_W = 6;
  localparam int ADR_LO = 2;
  // transfer rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RST = RATE_250K;
  // main status bit positions
  localparam int MSR_RQM = 7;
  localparam int MSR_DIO = 6;
  localparam int MSR_NDMA = 5;
  localparam int MSR_CB = 4;
  // first result status byte fields
  localparam int ST0_CODE_HI = 7;
  localparam int ST0_CODE_LO = 6;
  localparam int ST0_POS = 5;
  localparam int ST0_FAULT = 4;
  localparam int ST0_HEAD = 2;
  localparam logic [1:0] CODE_OK = 2'h0;
  localparam logic [1:0] CODE_ABN = 2'h1;
  localparam logic [1:0] CODE_INV = 2'h2;
  localparam logic [1:0] CODE_POLL = 2'h3;
  // interrupt status bits
  localparam int EV_RES = 0;
  localparam int EV_PACE = 1;
  localparam int EV_SEEK = 2;
  localparam int EV_W = 3;
  // command opcodes (low five bits of the first byte)
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_HOME = 5'h07;
  localparam logic [4:0] OP_SENSE = 5'h08;
  localparam logic [4:0] OP_SEEK = 5'h0F;
  localparam logic [7:0] XLEN_RST = 8'h04;
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_EXEC = 2'b01,
    PH_RES = 2'b10
  } phase_t;
endpackage : floppy_ctrl_pkg

// ==== core/floppy_host_phase_ctrl.sv ====
// host register interface and phase sequencer of the floppy controller
module floppy_host_phase_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic media_change_pin_n,
  input wire logic track_zero_pin_n,
  output logic [1:0] transfer_rate_sel,
  output logic dma_request_line_n,
  output logic host_interrupt
);

  typedef struct packed {
    floppy_ctrl_pkg::phase_t phase;
    logic [3:0] idx;
    logic [3:0] need;
    logic [2:0] rlen;
    logic xfer;
    logic inv;
    logic [4:0] opc;
    logic [7:0] p1;
    logic [7:0] cyl;
    logic [7:0] st0;
    logic [7:0] left;
    logic [7:0] xlen;
    logic [1:0] rate;
    logic dma;
    logic seek_pend;
    logic pos;
    logic fault;
    logic gap;
    logic ack;
    logic [7:0] rdat;
    logic [2:0] ists;
    logic [2:0] ien;
    logic m1;
    logic m2;
    logic t1;
    logic t2;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic take;
  logic wr;
  logic rd;
  logic [3:0] ix;
  logic request_for_master;
  logic transfer_direction;
  logic busy;
  logic data_wr;
  logic data_rd;
  logic cmd_end;
  logic x_end;
  logic [4:0] op;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [1:0] code;
  logic [7:0] rbyte;
  localparam int ST0_HI = floppy_ctrl_pkg::ST0_CODE_HI;

  // request is withheld for one cycle after every byte, the cycle that carries its acknowledge,
  // so no status read can see the drop; only the dma request line shows it
  assign request_for_master = !s_q.gap;
  assign transfer_direction = s_q.phase == floppy_ctrl_pkg::PH_RES ||
    (s_q.phase == floppy_ctrl_pkg::PH_EXEC &&
     s_q.opc == floppy_ctrl_pkg::OP_READ);
  assign busy = s_q.phase != floppy_ctrl_pkg::PH_CMD || s_q.idx != 4'h0;
  assign take = cyc_i && stb_i && !s_q.ack;
  assign ix = adr_i[5:2];
  assign wr = take && we_i && sel_i[0];
  assign rd = take && !we_i;
  // a data byte moves only when the handshake bits allow it
  assign data_wr = wr && ix == floppy_ctrl_pkg::IX_DATA && request_for_master && !transfer_direction;
  assign data_rd = rd && ix == floppy_ctrl_pkg::IX_DATA && request_for_master && transfer_direction;
  // the opcode byte is only on the bus during a command-phase first write;
  // elsewhere the write data is unrelated and must not steer the decode
  assign op = (s_q.phase == floppy_ctrl_pkg::PH_CMD && s_q.idx == 4'h0) ?
    dat_i[4:0] : s_q.opc;

  // result byte selected by the byte index, one per access
  always_comb
  begin
    if (s_q.idx == 4'h0)
      rbyte = s_q.st0;
    else if (s_q.idx == 4'h1)
      rbyte = s_q.cyl;
    else
      rbyte = 8'h00;
  end

  always_comb
  begin
    s_d = s_q;
    ev = 3'h0;
    clr = 3'h0;
    cmd_end = 1'b0;
    x_end = 1'b0;
    code = floppy_ctrl_pkg::CODE_OK;
    s_d.ack = take;
    s_d.gap = 1'b0;
    // two flops per pin; only the second is looked at
    s_d.m1 = media_change_pin_n;
    s_d.m2 = s_q.m1;
    s_d.t1 = track_zero_pin_n;
    s_d.t2 = s_q.t1;

    // register reads; unmapped indices answer zero
    if (rd)
    begin
      unique case (ix)
        floppy_ctrl_pkg::IX_MSR:
          s_d.rdat = {request_for_master, transfer_direction, !s_q.dma, busy, 4'h0};
        floppy_ctrl_pkg::IX_DATA:
          if (!request_for_master || !transfer_direction)
            s_d.rdat = 8'h00;
          else if (s_q.phase == floppy_ctrl_pkg::PH_RES)
            s_d.rdat = rbyte;
          else
            s_d.rdat = s_q.left;
        floppy_ctrl_pkg::IX_DIRDCR:
          s_d.rdat = {~s_q.m2, 7'h00};
        floppy_ctrl_pkg::IX_ISTS:
          s_d.rdat = {5'h00, s_q.ists};
        floppy_ctrl_pkg::IX_IEN:
          s_d.rdat = {5'h00, s_q.ien};
        floppy_ctrl_pkg::IX_XLEN:
          s_d.rdat = s_q.xlen;
        default:
          s_d.rdat = 8'h00;
      endcase
    end

    // plain register writes; the rate register keeps only two bits
    if (wr)
    begin
      unique case (ix)
        floppy_ctrl_pkg::IX_DIRDCR:
          s_d.rate = dat_i[1:0];
        floppy_ctrl_pkg::IX_IEN:
          s_d.ien = dat_i[2:0];
        floppy_ctrl_pkg::IX_ICLR:
          clr = dat_i[2:0];
        floppy_ctrl_pkg::IX_XLEN:
          s_d.xlen = dat_i[7:0];
        default:
          s_d.ien = s_q.ien;
      endcase
    end

    // command bytes: opcode first, then its parameters in order
    if (data_wr && s_q.phase == floppy_ctrl_pkg::PH_CMD)
    begin
      s_d.gap = 1'b1;
      if (s_q.idx == 4'h0)
      begin
        s_d.opc = dat_i[4:0];
        s_d.inv = 1'b0;
        s_d.xfer = 1'b0;
        s_d.rlen = 3'h0;
        unique case (dat_i[4:0])
          floppy_ctrl_pkg::OP_SPECIFY:
            s_d.need = 4'h2;
          floppy_ctrl_pkg::OP_HOME:
            s_d.need = 4'h1;
          floppy_ctrl_pkg::OP_SEEK:
            s_d.need = 4'h2;
          floppy_ctrl_pkg::OP_SENSE:
          begin
            s_d.need = 4'h0;
            s_d.rlen = 3'h2;
          end
          floppy_ctrl_pkg::OP_READ, floppy_ctrl_pkg::OP_WRITE:
          begin
            s_d.need = 4'h8;
            s_d.xfer = 1'b1;
            s_d.rlen = 3'h7;
          end
          default:
          begin
            s_d.need = 4'h0;
            s_d.inv = 1'b1;
            s_d.rlen = 3'h1;
          end
        endcase
      end
      else if (s_q.idx == 4'h1)
        s_d.p1 = dat_i[7:0];
      else if (s_q.idx == 4'h2 && s_q.opc == floppy_ctrl_pkg::OP_SEEK)
        s_d.cyl = dat_i[7:0];
      // last byte of the set closes the command phase
      // on the opcode byte the stored count is stale; only the new one counts
      if (s_q.idx == 4'h0 ? s_d.need == 4'h0 : s_q.idx == s_q.need)
        cmd_end = 1'b1;
      else
        s_d.idx = s_q.idx + 4'h1;
      if (cmd_end && op == floppy_ctrl_pkg::OP_SPECIFY)
        s_d.dma = !dat_i[0];
      if (cmd_end && (op == floppy_ctrl_pkg::OP_SEEK ||
          op == floppy_ctrl_pkg::OP_HOME))
      begin
        s_d.seek_pend = 1'b1;
        s_d.pos = 1'b1;
        // home is treated as instant: pin still high means no track zero
        s_d.fault = op == floppy_ctrl_pkg::OP_HOME && s_q.t2;
        if (op == floppy_ctrl_pkg::OP_HOME)
          s_d.cyl = 8'h00;
        ev[floppy_ctrl_pkg::EV_SEEK] = 1'b1;
      end
    end

    // execution bytes, either direction, counted down
    if ((data_wr || data_rd) && s_q.phase == floppy_ctrl_pkg::PH_EXEC)
    begin
      s_d.gap = 1'b1;
      s_d.left = s_q.left - 8'h01;
      x_end = s_q.left == 8'h01;
    end

    // result bytes; the last one hands control back to the host
    if (data_rd && s_q.phase == floppy_ctrl_pkg::PH_RES)
    begin
      s_d.gap = 1'b1;
      if (s_q.idx == {1'b0, s_q.rlen} - 4'h1)
      begin
        s_d.phase = floppy_ctrl_pkg::PH_CMD;
        s_d.idx = 4'h0;
      end
      else
        s_d.idx = s_q.idx + 4'h1;
    end

    // advance to execution, result or straight back to command
    if (cmd_end && s_d.xfer && s_q.xlen != 8'h00)
    begin
      s_d.phase = floppy_ctrl_pkg::PH_EXEC;
      s_d.left = s_q.xlen;
      s_d.idx = 4'h0;
    end
    else if (cmd_end || x_end)
    begin
      s_d.idx = 4'h0;
      if (s_d.rlen != 3'h0)
      begin
        s_d.phase = floppy_ctrl_pkg::PH_RES;
        ev[floppy_ctrl_pkg::EV_RES] = 1'b1;
        if (s_d.inv)
          code = floppy_ctrl_pkg::CODE_INV;
        else if (op == floppy_ctrl_pkg::OP_SENSE && !s_q.seek_pend)
          code = floppy_ctrl_pkg::CODE_INV;
        else
          code = floppy_ctrl_pkg::CODE_OK;
        s_d.st0 = 8'h00;
        s_d.st0[ST0_HI:floppy_ctrl_pkg::ST0_CODE_LO] = code;
        if (op == floppy_ctrl_pkg::OP_SENSE)
        begin
          s_d.st0[floppy_ctrl_pkg::ST0_POS] = s_q.pos;
          s_d.st0[floppy_ctrl_pkg::ST0_FAULT] = s_q.fault;
          s_d.seek_pend = 1'b0;
          s_d.pos = 1'b0;
          s_d.fault = 1'b0;
        end
        if (!s_d.inv)
        begin
          s_d.st0[floppy_ctrl_pkg::ST0_HEAD] = s_d.p1[2];
          s_d.st0[1:0] = s_d.p1[1:0];
        end
      end
      else
        s_d.phase = floppy_ctrl_pkg::PH_CMD;
    end

    // in non-dma mode every new execution byte raises an interrupt
    if (s_d.phase == floppy_ctrl_pkg::PH_EXEC && !s_d.dma &&
        (s_d.gap == 1'b0) &&
        (s_q.gap || s_q.phase != floppy_ctrl_pkg::PH_EXEC))
      ev[floppy_ctrl_pkg::EV_PACE] = 1'b1;

    // a new event beats a clear landing in the same cycle
    s_d.ists = (s_q.ists & ~clr) | ev;
  end

  // single register stage for all state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.phase <= floppy_ctrl_pkg::PH_CMD;
      s_q.rate <= floppy_ctrl_pkg::RATE_RST;
      s_q.xlen <= floppy_ctrl_pkg::XLEN_RST;
      s_q.m1 <= 1'b1;
      s_q.m2 <= 1'b1;
      s_q.t1 <= 1'b1;
      s_q.t2 <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // data and acknowledge come straight from flops
  assign dat_o = {24'h000000, s_q.rdat};
  assign ack_o = s_q.ack;
  assign transfer_rate_sel = s_q.rate;
  // dma pacing holds the request low while a byte is wanted
  assign dma_request_line_n = !(s_q.phase == floppy_ctrl_pkg::PH_EXEC &&
    s_q.dma && request_for_master);
  assign host_interrupt = |(s_q.ists & s_q.ien);

  // request and direction pair as the host sees it
  function automatic logic [1:0] main_bits();
    main_bits = {request_for_master, transfer_direction};
  endfunction : main_bits

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reset_cmd_phase: assert property (
    $past(rst) |-> s_q.phase == floppy_ctrl_pkg::PH_CMD && request_for_master && !transfer_direction)
    else $error("not in command phase after reset");
  a_rate_default: assert property (
    $past(rst) && !$past(wr) |-> transfer_rate_sel == 2'h2)
    else $error("rate not 250K after reset");
  a_rqm_drop: assert property (
    data_wr || data_rd |=> !request_for_master ##1 request_for_master)
    else $error("request did not drop for one cycle");
  a_dir_inverse: assert property (
    rd && ix == floppy_ctrl_pkg::IX_DIRDCR |=>
      dat_o[7] == !$past(s_q.m2) && dat_o[6:0] == 7'h00)
    else $error("change bit not inverted pin");
  a_res_handshake: assert property (
    s_q.phase == floppy_ctrl_pkg::PH_RES && !s_q.gap |->
      main_bits() == 2'h3)
    else $error("result phase without request and direction");
  a_res_end: assert property (
    data_rd && s_q.phase == floppy_ctrl_pkg::PH_RES &&
      s_q.idx == {1'b0, s_q.rlen} - 4'h1 |-> ##2 request_for_master && !transfer_direction && !busy)
    else $error("result end did not free controller");
  a_invalid_code: assert property (
    data_wr && s_q.phase == floppy_ctrl_pkg::PH_CMD && s_q.idx == 4'h0 &&
      s_d.inv |=> s_q.phase == floppy_ctrl_pkg::PH_RES &&
      s_q.st0[7:6] == 2'h2 && s_q.ists[floppy_ctrl_pkg::EV_RES])
    else $error("invalid opcode not reported");
  a_dma_pace: assert property (
    s_q.phase == floppy_ctrl_pkg::PH_EXEC && s_q.dma && !s_q.gap |->
      !dma_request_line_n)
    else $error("dma request missing in execution");

  c_invalid: cover property (s_q.phase == floppy_ctrl_pkg::PH_RES &&
    s_q.st0[7:6] == 2'h2);
  c_exec_done: cover property (s_q.phase == floppy_ctrl_pkg::PH_EXEC ##1
    s_q.phase == floppy_ctrl_pkg::PH_RES);
  c_seek_sense: cover property (s_q.st0[5] &&
    s_q.phase == floppy_ctrl_pkg::PH_RES);

endmodule : floppy_host_phase_ctrl

// ==== sim/host_cpu_model.sv ====
// host processor model: classic bus master driving the register port
module host_cpu_model (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [5:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0;
  int stuck_count = 0;

  // idle levels before the first cycle; data is not left at a stale value
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    wdat = 32'hFFFFFFFF;
  end

  // one classic cycle; request held until ack is seen at an edge
  task automatic bus_xfer(input logic w, input logic [3:0] ix,
                          input logic [3:0] be, input logic [7:0] d,
                          output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= be;
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~{24'h000000, d};
    repeat (gap) @(posedge clk);
  endtask : bus_xfer

  task automatic bus_wr(input logic [3:0] ix, input logic [7:0] d);
    logic [7:0] q;
    bus_xfer(1'b1, ix, 4'h1, d, q);
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] ix, output logic [7:0] q);
    bus_xfer(1'b0, ix, 4'h1, 8'h00, q);
  endtask : bus_rd

  // polls request and direction; a bounded poll so a stuck device shows
  task automatic wait_status(input logic [1:0] want);
    logic [7:0] s;
    int n;
    n = 0;
    do
    begin
      bus_rd(floppy_ctrl_pkg::IX_MSR, s);
      n++;
    end
    while (s[7:6] !== want && n < 40);
    if (s[7:6] !== want)
      stuck_count++;
  endtask : wait_status

  task automatic put_byte(input logic [7:0] d);
    logic [7:0] q;
    wait_status(2'b10);
    bus_xfer(1'b1, floppy_ctrl_pkg::IX_DATA, 4'h1, d, q);
  endtask : put_byte

  task automatic get_byte(output logic [7:0] q);
    wait_status(2'b11);
    bus_rd(floppy_ctrl_pkg::IX_DATA, q);
  endtask : get_byte
endmodule : host_cpu_model

// ==== sim/tb_top.sv ====
// self-checking bench for the floppy host phase sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc_i, stb_i, we_i;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic ack_o, dma_request_line_n, host_interrupt;
  logic media_change_pin_n = 1'b1;
  logic track_zero_pin_n = 1'b1;
  logic [1:0] transfer_rate_sel;
  logic [7:0] q;
  // idle main status; bit 5 follows the pacing mode, non-dma after reset
  logic [7:0] msr_idle = 8'hA0;
  int fail_count = 0;
  int cmp_count = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  host_cpu_model i_host_cpu_model (.clk(clk), .cyc(cyc_i), .stb(stb_i),
    .we(we_i), .adr(adr_i), .sel(sel_i), .wdat(dat_i), .rdat(dat_o),
    .ack(ack_o));

  floppy_host_phase_ctrl i_floppy_host_phase_ctrl (.clk(clk), .rst(rst),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .media_change_pin_n(media_change_pin_n),
    .track_zero_pin_n(track_zero_pin_n),
    .transfer_rate_sel(transfer_rate_sel),
    .dma_request_line_n(dma_request_line_n),
    .host_interrupt(host_interrupt));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp_pin(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp_pin

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, fail_count);
  endtask : test_end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // sends an opcode and its parameters; unlisted parameters are zero
  task automatic send_cmd(input logic [7:0] op, input int np,
                          input logic [7:0] p1, input logic [7:0] p2);
    i_host_cpu_model.put_byte(op);
    for (int i = 0; i < np; i++)
      i_host_cpu_model.put_byte(i == 0 ? p1 : (i == 1 ? p2 : 8'h00));
  endtask : send_cmd

  // reads n result bytes, keeps the first two, then expects command phase
  task automatic drain(input int n, output logic [7:0] b0,
                       output logic [7:0] b1);
    logic [7:0] r;
    for (int i = 0; i < n; i++)
    begin
      i_host_cpu_model.get_byte(r);
      if (i == 0)
        b0 = r;
      if (i == 1)
        b1 = r;
    end
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_MSR, r);
    cmp8(r, msr_idle);
  endtask : drain

  // watchdog sized well above the expected several hundred cycles
  initial
  begin
    #(20 * 20000);
    fail_count++;
    final_report();
  end

  initial
  begin
    logic [7:0] s0, s1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cmp8({6'h00, transfer_rate_sel}, 8'h02);
    cmp_pin(dma_request_line_n, 1'b1);
    cmp_pin(host_interrupt, 1'b0);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_MSR, q);
    cmp8(q, 8'hA0);
    test_end("reset");
    // every rate code, with reserved bits set, then a write lacking sel
    for (int i = 0; i < 4; i++)
    begin
      i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_DIRDCR, 8'hFC | 8'(i));
      cmp8({6'h00, transfer_rate_sel}, 8'(i));
    end
    i_host_cpu_model.bus_xfer(1'b1, floppy_ctrl_pkg::IX_DIRDCR, 4'hE,
                              8'h00, q);
    cmp8({6'h00, transfer_rate_sel}, 8'h03);
    for (int i = 0; i < 2; i++)
    begin
      media_change_pin_n <= i[0];
      repeat (4) @(posedge clk);
      i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_DIRDCR, q);
      cmp8(q & 8'h80, i[0] ? 8'h00 : 8'h80);
    end
    i_host_cpu_model.bus_rd(4'h0, q);
    cmp8(q, 8'h00);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_DATA, q);
    cmp8(q, 8'h00);
    test_end("registers");
    // seek raises an enabled interrupt; sense reports it
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_IEN, 8'h04);
    send_cmd(8'h0F, 2, 8'h05, 8'h22);
    repeat (3) @(posedge clk);
    cmp_pin(host_interrupt, 1'b1);
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_ICLR, 8'h04);
    repeat (2) @(posedge clk);
    cmp_pin(host_interrupt, 1'b0);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_MSR, q);
    cmp8(q, msr_idle);
    send_cmd(8'h08, 0, 8'h00, 8'h00);
    drain(2, s0, s1);
    cmp8(s0, 8'h25);
    cmp8(s1, 8'h22);
    test_end("seek");
    // home with the track-zero pin absent, interrupt masked, then present
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_IEN, 8'h00);
    send_cmd(8'h07, 1, 8'h02, 8'h00);
    repeat (3) @(posedge clk);
    cmp_pin(host_interrupt, 1'b0);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_ISTS, q);
    cmp8(q & 8'h04, 8'h04);
    send_cmd(8'h08, 0, 8'h00, 8'h00);
    drain(2, s0, s1);
    cmp8(s0 & 8'h37, 8'h32);
    track_zero_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    send_cmd(8'h07, 1, 8'h00, 8'h00);
    send_cmd(8'h08, 0, 8'h00, 8'h00);
    drain(2, s0, s1);
    cmp8(s0 & 8'h37, 8'h20);
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_ICLR, 8'h07);
    send_cmd(8'h1F, 0, 8'h00, 8'h00);
    drain(1, s0, s1);
    cmp8(s0, 8'h80);
    test_end("home");
    // non-dma read of two bytes with the pacing interrupt enabled; each byte is fetched after a status poll
    send_cmd(8'h03, 2, 8'h00, 8'h01);
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_XLEN, 8'h02);
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_IEN, 8'h02);
    send_cmd(8'h06, 8, 8'h00, 8'h00);
    repeat (3) @(posedge clk);
    cmp_pin(host_interrupt, 1'b1);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_MSR, q);
    cmp8(q, 8'hF0);
    i_host_cpu_model.get_byte(q);
    cmp8(q, 8'h02);
    i_host_cpu_model.get_byte(q);
    cmp8(q, 8'h01);
    drain(7, s0, s1);
    cmp8(s0 & 8'hC7, 8'h00);
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_ICLR, 8'h07);
    test_end("read");
    // dma write of one byte with a slow host
    i_host_cpu_model.gap = 3;
    send_cmd(8'h03, 2, 8'h00, 8'h00);
    msr_idle = 8'h80;
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_XLEN, 8'h01);
    send_cmd(8'h05, 8, 8'h01, 8'h00);
    repeat (3) @(posedge clk);
    cmp_pin(dma_request_line_n, 1'b0);
    i_host_cpu_model.put_byte(8'hA5);
    repeat (2) @(posedge clk);
    cmp_pin(dma_request_line_n, 1'b1);
    drain(7, s0, s1);
    cmp8(s0 & 8'h03, 8'h01);
    i_host_cpu_model.gap = 0;
    // zero length skips execution straight to results
    i_host_cpu_model.bus_wr(floppy_ctrl_pkg::IX_XLEN, 8'h00);
    send_cmd(8'h06, 8, 8'h00, 8'h00);
    repeat (3) @(posedge clk);
    i_host_cpu_model.bus_rd(floppy_ctrl_pkg::IX_MSR, q);
    cmp8(q, 8'hD0);
    drain(7, s0, s1);
    test_end("dma");
    cmp8(8'(i_host_cpu_model.stuck_count), 8'h00);
    final_report();
  end
endmodule : tb_top
